// [dv/i2c_double_buffered_receiver_tb.sv]
// Self-checking bench of the receiver against a remote bus master.
// Assumes the receiver and the remote master model are compiled first.
`timescale 1ns/1ps

module i2c_double_buffered_receiver_tb;
   logic mclk_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic rx_en_in = 1'h1;
   logic master_mode_in = 1'h0;
   logic rd_in = 1'h0;
   logic scl_oe, sda_oe, scl_low, sda_low, rdy, clk_low, bus_err, m_abort;
   logic scl_o, sda_o;
   int n_hold = 0;
   logic [7:0] rx_buf;
   int n_fail = 0;
   int checked = 0;
   int n_err = 0;
   int n_abort = 0;
   int cyc = 0;
   // Open-drain wires with pull-ups.
   // A driven level other than low would fight the pull-up and shows as high here.
   wire scl_w = ~scl_low & (scl_oe ? scl_o : 1'h1);
   wire sda_w = ~sda_low & (sda_oe ? sda_o : 1'h1);

   always #2 mclk_in = ~mclk_in;

   rxdb_receiver i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl_w), .sda_in(sda_w),
      .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe), .rx_en_in(rx_en_in),
      .master_mode_in(master_mode_in), .rd_in(rd_in), .rx_holding_buffer_out(rx_buf),
      .rx_byte_ready_flag_out(rdy), .clock_line_low_flag_out(clk_low), .bus_error_out(bus_err),
      .master_abort_out(m_abort));

   rxdb_far_master i_far (.scl_w_in(scl_w), .sda_w_in(sda_w), .scl_low_out(scl_low),
      .sda_low_out(sda_low));

   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (bus_err === 1'h1) n_err <= n_err + 1;
      if (m_abort === 1'h1) n_abort <= n_abort + 1;
      if (scl_oe === 1'h1) n_hold <= n_hold + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rd_byte(output logic [7:0] d);
      @(negedge mclk_in);
      d = rx_buf;
      rd_in = 1'h1;
      @(negedge mclk_in);
      rd_in = 1'h0;
   endtask : rd_byte

   // The reader empties the buffer after each acknowledge, before the next byte ends, so no stretch is needed.
   task automatic test_prompt;
      logic ack;
      logic [7:0] d;
      int h0;
      h0 = n_hold;
      i_far.send_start();
      i_far.send_byte(8'h96, ack);
      chk({7'h00, ack}, 8'h00, "ack prompt first");
      rd_byte(d);
      chk(d, 8'h96, "prompt first");
      i_far.send_byte(8'h4B, ack);
      chk({7'h00, ack}, 8'h00, "ack prompt second");
      rd_byte(d);
      chk(d, 8'h4B, "prompt last");
      i_far.send_stop();
      chk(8'(n_hold - h0), 8'h00, "no stretch");
      chk(8'(n_err), 8'h00, "no error early read");
      $display("test prompt done");
   endtask : test_prompt

   // Second byte arrives while the first is unread, so the clock is stretched.
   task automatic test_stretch;
      logic ack;
      logic [7:0] d;
      int n;
      i_far.send_start();
      i_far.send_byte(8'hA5, ack);
      chk({7'h00, ack}, 8'h00, "ack first");
      chk({7'h00, rdy}, 8'h01, "flag set");
      fork
         i_far.send_byte(8'h3C, ack);
         begin
            n = 0;
            while (scl_oe !== 1'h1 && n < 2000) begin
               @(negedge mclk_in);
               n++;
            end
            repeat (100) @(negedge mclk_in);
            chk({7'h00, scl_oe}, 8'h01, "clock held");
            chk({7'h00, clk_low}, 8'h01, "clock low flag");
            rd_byte(d);
            chk(d, 8'hA5, "read after wait");
         end
      join
      chk({7'h00, ack}, 8'h00, "ack second");
      rd_byte(d);
      chk(d, 8'h3C, "last byte");
      @(negedge mclk_in);
      chk({7'h00, rdy}, 8'h00, "flag clear");
      i_far.send_stop();
      chk(8'(n_err), 8'h00, "no error");
      $display("test stretch done");
   endtask : test_stretch

   task automatic test_window(input logic mode);
      logic ack;
      logic [7:0] d;
      int n;
      int e0;
      int a0;
      @(negedge mclk_in);
      master_mode_in = mode;
      e0 = n_err;
      a0 = n_abort;
      i_far.send_start();
      i_far.send_byte(8'h5A, ack);
      fork
         i_far.send_byte(8'hFF, ack);
         begin
            n = 0;
            while (i_far.bit_idx != 6 && n < 2000) begin
               @(negedge mclk_in);
               n++;
            end
            repeat (5) @(negedge mclk_in);
            rd_byte(d);
         end
      join
      i_far.send_stop();
      chk(8'(n_err - e0), 8'h01, "window error");
      chk(8'(n_abort - a0), {7'h00, mode}, "abort pulse");
      chk({7'h00, ack}, 8'h01, "nack after error");
      chk(d, 8'h5A, "window read data");
      chk(rx_buf, 8'h5A, "byte lost");
      chk({7'h00, rdy}, 8'h00, "flag after error");
      $display("test window mode %0d done", mode);
   endtask : test_window

   initial begin
      repeat (12) @(negedge mclk_in);
      rst_n_in = 1'h1;
      repeat (3) @(negedge mclk_in);
      chk({2'h0, scl_oe, sda_oe, rdy, clk_low, bus_err, m_abort}, 8'h00, "reset outputs");
      chk(rx_buf, 8'h00, "reset buffer");
      $display("test reset done");
      test_prompt();
      test_stretch();
      test_window(1'h0);
      test_window(1'h1);
      report_and_stop();
   end
endmodule : i2c_double_buffered_receiver_tb

// [dv/rxdb_far_master.sv]
// Remote bus master model: makes the clock line and sends bytes.
// Assumes the bench resolves both wires with pull-ups and feeds them back.
`timescale 1ns/1ps

module rxdb_far_master (
   // Resolved wire levels
   input wire logic scl_w_in,
   input wire logic sda_w_in,
   // High pulls the line low
   output logic scl_low_out,
   output logic sda_low_out
);
   int bit_idx = -1;

   initial begin
      scl_low_out = 1'h0;
      sda_low_out = 1'h0;
   end

   task automatic half;
      #62.5;
   endtask : half

   // The device may stretch the low phase, so the wire is awaited.
   task automatic rise;
      int n;
      n = 0;
      scl_low_out = 1'h0;
      while (scl_w_in !== 1'h1 && n < 5000) begin
         #4;
         n++;
      end
      half();
   endtask : rise

   task automatic send_start;
      sda_low_out = 1'h1;
      half();
      scl_low_out = 1'h1;
      half();
   endtask : send_start

   task automatic send_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_idx = 7 - i;
         sda_low_out = ~d[i];
         half();
         rise();
         scl_low_out = 1'h1;
      end
      bit_idx = 8;
      sda_low_out = 1'h0;
      half();
      rise();
      ack = sda_w_in;
      scl_low_out = 1'h1;
      bit_idx = -1;
   endtask : send_byte

   task automatic send_stop;
      sda_low_out = 1'h1;
      half();
      rise();
      sda_low_out = 1'h0;
      half();
   endtask : send_stop
endmodule : rxdb_far_master

// [hdl/rxdb_receiver.sv]
// Receive path of a two-wire bus controller, master or slave receiver,
// with a shift register feeding one holding buffer.
// Assumes the bus lines are asynchronous pins and the reader (CPU or DMA)
// runs on mclk_in.
`timescale 1ns/1ps
`include "rxdb_defines.svh"

module rxdb_receiver #(
   parameter int DATA_W = 8
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe_out,
   output logic sda_out,
   output logic sda_oe_out,
   // Configuration
   input wire logic rx_en_in,
   input wire logic master_mode_in,
   // Reader side
   input wire logic rd_in,
   output logic [DATA_W-1:0] rx_holding_buffer_out,
   output logic rx_byte_ready_flag_out,
   output logic clock_line_low_flag_out,
   output logic bus_error_out,
   output logic master_abort_out
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   // The fault window sits at the seventh bit, so a byte needs at least seven.
   if (DATA_W < 7 || DATA_W > 15) begin : g_bad_width
      $error("rxdb_receiver: DATA_W must lie between 7 and 15");
   end

   localparam logic [3:0] LAST_CNT = 4'(DATA_W);

   // ----------------------------------------------------------------
   // Line synchronisation
   // ----------------------------------------------------------------
   rxdb_pkg::rxdb_line_t line_raw;
   rxdb_pkg::rxdb_line_t line_s;
   rxdb_pkg::rxdb_line_t line_rise;
   rxdb_pkg::rxdb_line_t line_fall;

   assign line_raw = '{scl: scl_in, sda: sda_in};

   rxdb_sync u_sync (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .line_in(line_raw),
      .line_s_out(line_s),
      .rise_out(line_rise),
      .fall_out(line_fall)
   );

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   rxdb_pkg::rxdb_state_t st_r;
   rxdb_pkg::rxdb_state_t st_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [DATA_W-1:0] shift_r;
   logic [DATA_W-1:0] shift_nxt;
   logic [DATA_W-1:0] buf_nxt;
   logic flag_nxt;

   wire start_det = line_fall.sda & line_s.scl;
   wire stop_det = line_rise.sda & line_s.scl;
   wire bit_take = (st_r == rxdb_pkg::RXDB_DATA) & line_rise.scl & (cnt_r < LAST_CNT);
   wire byte_done = (st_r == rxdb_pkg::RXDB_DATA) & line_fall.scl & (cnt_r == LAST_CNT);
   // Buffer free at the end of a byte: load at once and acknowledge.
   wire load_direct = byte_done & ~rx_byte_ready_flag_out;
   // Buffer still full: the clock is held low until the reader empties it.
   wire load_stretch = (st_r == rxdb_pkg::RXDB_STRETCH) & rd_in;
   wire load = load_direct | load_stretch;
   // A read that races the seventh bit of the next byte breaks the transfer.
   // Reads before or after that bit are harmless.
   wire err_hit = (st_r == rxdb_pkg::RXDB_DATA) & (cnt_r == `RXDB_WIN_CNT)
                  & rx_byte_ready_flag_out & rd_in;
   wire ack_end = (st_r == rxdb_pkg::RXDB_ACK) & line_fall.scl;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      if (!rx_en_in || stop_det) begin
         st_nxt = rxdb_pkg::RXDB_IDLE;
      end else if (start_det) begin
         st_nxt = rxdb_pkg::RXDB_DATA;
         cnt_nxt = 4'h0;
      end else begin
         unique case (st_r)
            rxdb_pkg::RXDB_IDLE: begin
               cnt_nxt = 4'h0;
            end
            rxdb_pkg::RXDB_DATA: begin
               if (err_hit) begin
                  // Both roles drop to idle: the byte is lost, and as a slave
                  // the released data line answers the ninth clock with NACK.
                  st_nxt = rxdb_pkg::RXDB_IDLE;
                  cnt_nxt = 4'h0;
               end else if (bit_take) begin
                  shift_nxt = {shift_r[DATA_W-2:0], line_s.sda};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (load_direct) begin
                  st_nxt = rxdb_pkg::RXDB_ACK;
               end else if (byte_done) begin
                  st_nxt = rxdb_pkg::RXDB_STRETCH;
               end
            end
            rxdb_pkg::RXDB_STRETCH: begin
               if (load_stretch) begin
                  st_nxt = rxdb_pkg::RXDB_ACK;
               end
            end
            rxdb_pkg::RXDB_ACK: begin
               if (ack_end) begin
                  st_nxt = rxdb_pkg::RXDB_DATA;
                  cnt_nxt = 4'h0;
               end
            end
         endcase
      end
   end

   assign buf_nxt = load ? shift_r : rx_holding_buffer_out;
   // A load in the same cycle as a read wins, so no byte is missed.
   assign flag_nxt = load | (rx_byte_ready_flag_out & ~rd_in);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         st_r <= rxdb_pkg::RXDB_IDLE;
         cnt_r <= 4'h0;
         shift_r <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rx_holding_buffer_out <= DATA_W'(`RXDB_BUF_RST);
         rx_byte_ready_flag_out <= 1'h0;
         clock_line_low_flag_out <= 1'h0;
         bus_error_out <= 1'h0;
         master_abort_out <= 1'h0;
      end else begin
         rx_holding_buffer_out <= buf_nxt;
         rx_byte_ready_flag_out <= flag_nxt;
         clock_line_low_flag_out <= ~line_s.scl;
         bus_error_out <= err_hit;
         master_abort_out <= err_hit & master_mode_in;
      end
   end

   // Pin drivers: both lines are only ever pulled low.
   // After a stretch the clock is held one cycle into the acknowledge, so the data
   // line is already low when the clock rises and no start condition is formed.
   wire clk_hold = (st_nxt == rxdb_pkg::RXDB_STRETCH) | (st_r == rxdb_pkg::RXDB_STRETCH);

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         scl_out <= 1'h0;
         sda_out <= 1'h0;
         scl_oe_out <= 1'h0;
         sda_oe_out <= 1'h0;
      end else begin
         scl_out <= 1'h0;
         sda_out <= 1'h0;
         scl_oe_out <= clk_hold;
         sda_oe_out <= (st_nxt == rxdb_pkg::RXDB_ACK);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   a_flag_on_load: assert property (load |=> rx_byte_ready_flag_out && rx_holding_buffer_out == $past(shift_r))
      else $error("byte-ready flag or buffer not updated on load");
   a_flag_read_clear: assert property (rd_in && !load |=> !rx_byte_ready_flag_out)
      else $error("byte-ready flag not cleared by read");
   a_ack_after_byte: assert property ($rose(sda_oe_out) |-> rx_byte_ready_flag_out && $past(cnt_r) == LAST_CNT)
      else $error("acknowledge driven without a completed byte");
   a_error_window: assert property (bus_error_out |-> $past(cnt_r) == `RXDB_WIN_CNT && $past(rd_in))
      else $error("bus error outside the seventh-bit window");
   a_error_raised: assert property (err_hit |=> bus_error_out ##0 st_r == rxdb_pkg::RXDB_IDLE)
      else $error("window read did not raise the error");
   a_master_abort: assert property (err_hit && master_mode_in |=> master_abort_out && !sda_oe_out)
      else $error("master receiver did not abort");
   a_slave_nack: assert property (err_hit && !master_mode_in && rx_en_in && !start_det
                                  |=> (!sda_oe_out && !master_abort_out)[*2])
      else $error("slave drove acknowledge after lost byte");
   a_clock_low_flag: assert property (!line_s.scl ##1 !line_s.scl |-> clock_line_low_flag_out)
      else $error("clock-low flag not set while clock held low");
   a_stretch_hold: assert property (st_r == rxdb_pkg::RXDB_STRETCH && !rd_in && rx_en_in && !stop_det && !start_det
                                    |=> scl_oe_out)
      else $error("clock released while the buffer is still full");

   c_normal_load: cover property (load_direct ##[1:300] ack_end);
   c_stretch_load: cover property (byte_done && rx_byte_ready_flag_out ##[1:300] load_stretch);
   c_slave_error: cover property (err_hit && !master_mode_in);
   c_master_error: cover property (err_hit && master_mode_in);

endmodule : rxdb_receiver

// [hdl/rxdb_sync.sv]
// Two-flop synchroniser for the bus lines plus edge detection.
// Assumes the lines are asynchronous to mclk_in.
`timescale 1ns/1ps
`include "rxdb_defines.svh"

module rxdb_sync (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Raw lines
   input wire rxdb_pkg::rxdb_line_t line_in,
   // Synchronised levels and one-cycle edges
   output rxdb_pkg::rxdb_line_t line_s_out,
   output rxdb_pkg::rxdb_line_t rise_out,
   output rxdb_pkg::rxdb_line_t fall_out
);

   rxdb_pkg::rxdb_line_t meta_r;
   rxdb_pkg::rxdb_line_t sync_r;
   rxdb_pkg::rxdb_line_t prev_r;

   // The first stage feeds only the second; edges compare stages two and three.
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         meta_r <= `RXDB_LINE_IDLE;
         sync_r <= `RXDB_LINE_IDLE;
         prev_r <= `RXDB_LINE_IDLE;
      end else begin
         meta_r <= line_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign line_s_out = sync_r;
   assign rise_out = sync_r & ~prev_r;
   assign fall_out = ~sync_r & prev_r;

endmodule : rxdb_sync

// [shared/rxdb_defines.svh]
// Constants of the double-buffered two-wire receiver: reset values and
// bit positions. Definitions only; included by bare name.
`ifndef RXDB_DEFINES_SVH
`define RXDB_DEFINES_SVH

// Idle level of both bus lines (released, pulled high).
`define RXDB_LINE_IDLE 2'h3
// Reset content of the holding buffer.
`define RXDB_BUF_RST 8'h00
// Bits already shifted in while the seventh bit of a byte is arriving.
`define RXDB_WIN_CNT 4'h6

`endif

// [shared/rxdb_pkg.sv]
// Types shared by the receiver and its line synchroniser.
// Assumes nothing beyond a SystemVerilog compiler.
package rxdb_pkg;

   // Both bus lines as one carrier; scl is the high bit.
   typedef struct packed {
      logic scl;
      logic sda;
   } rxdb_line_t;

   typedef enum logic [1:0] {
      RXDB_IDLE,
      RXDB_DATA,
      RXDB_STRETCH,
      RXDB_ACK
   } rxdb_state_t;

endpackage : rxdb_pkg
